/* verilog/lcfg_pkg.sv */
// constants and types for the lane d configuration block
`default_nettype none
package lcfg_pkg;
    localparam int unsigned LCFG_ADR_W = 8;
    localparam int unsigned LCFG_DAT_W = 32;
    localparam int unsigned LCFG_REG_W = 16;
    localparam int unsigned LCFG_FLD_W = 12;
    localparam int unsigned LCFG_IDX_W = 6;

    // register indices; byte address is four times the index
    localparam logic [5:0] LCFG_IDX_CFG = 6'h14;
    localparam logic [5:0] LCFG_IDX_EFF = 6'h15;

    // field positions in the configuration register
    localparam int unsigned B_CTC    = 11;
    localparam int unsigned B_MF_HI  = 10;
    localparam int unsigned B_MF_LO  = 9;
    localparam int unsigned B_LOSS   = 8;
    localparam int unsigned B_CFG_UP = 7;
    localparam int unsigned B_CFG_LO = 6;
    localparam int unsigned B_EMP_UP = 5;
    localparam int unsigned B_EMP_LO = 4;
    localparam int unsigned B_LPBK   = 3;
    localparam int unsigned B_PRBS   = 2;
    localparam int unsigned B_ALIGN  = 1;
    localparam int unsigned B_PWDN   = 0;

    // pin levels shown in the upper bits of the effective register
    localparam int unsigned P_STRAP_UP = 15;
    localparam int unsigned P_STRAP_LO = 14;
    localparam int unsigned P_PATTERN  = 13;
    localparam int unsigned P_ALIGN    = 12;

    // control register 0 and status register 22 positions
    localparam int unsigned C0_LPBK  = 14;
    localparam int unsigned C0_PWDN  = 11;
    localparam int unsigned S22_LOSS = 3;
    localparam int unsigned S22_PRBS = 7;

    localparam logic [11:0] LCFG_CFG_RESET = 12'h102;
    localparam logic [15:0] LCFG_WMASK     = 16'h0fff;
    // fields that are or'ed with the global register
    localparam logic [11:0] LCFG_OR_MASK   = 12'hef4;

    typedef enum logic [1:0] {
        MF_SIGNALLING = 2'b00,
        MF_COMMA      = 2'b01,
        MF_LOSS       = 2'b10,
        MF_PRBS_PASS  = 2'b11
    } lcfg_mf_t;

    typedef struct packed {
        logic ack;
    } lcfg_front_t;

    typedef struct packed {
        logic [11:0] cfg;
        logic [31:0] rdata;
        logic [15:0] eff;
        logic        sig_loss;
        logic        mf_pin;
    } lcfg_core_t;

    localparam lcfg_front_t LCFG_FRONT_RST = '{ack: 1'b0};
    localparam lcfg_core_t  LCFG_CORE_RST  = '{
        cfg:      LCFG_CFG_RESET,
        rdata:    32'h00000000,
        eff:      16'h0000,
        sig_loss: 1'b0,
        mf_pin:   1'b0
    };
endpackage
`default_nettype wire

/* verilog/lcfg_bus_if.sv */
// request signals from the bus front end to the register core
`timescale 1ns/1ns
`default_nettype none
interface lcfg_bus_if;
    logic        req;
    logic        we;
    logic [5:0]  idx;
    logic [15:0] wdata;
    logic [1:0]  wsel;

    modport front (
        output req,
        output we,
        output idx,
        output wdata,
        output wsel
    );
    modport core (
        input req,
        input we,
        input idx,
        input wdata,
        input wsel
    );
endinterface
`default_nettype wire

/* verilog/lcfg_wb_front.sv */
// classic wishbone slave front end with single-cycle acknowledge
`timescale 1ns/1ns
`default_nettype none
module lcfg_wb_front (
    input  wire logic                           clk_i,
    input  wire logic                           rst_i,
    input  wire logic                           ce_i,
    input  wire logic                           cyc_i,
    input  wire logic                           stb_i,
    input  wire logic                           we_i,
    input  wire logic [lcfg_pkg::LCFG_ADR_W-1:0] adr_i,
    input  wire logic [3:0]                     sel_i,
    input  wire logic [lcfg_pkg::LCFG_DAT_W-1:0] dat_i,
    output logic                                ack_o,
    lcfg_bus_if.front                           bus
);
    import lcfg_pkg::*;

    lcfg_front_t q;
    lcfg_front_t d;
    logic        take;

    // ack high for one cycle, then low so a held strobe is not retaken
    assign take = cyc_i & stb_i & ~q.ack;

    always_comb begin
        d     = q;
        d.ack = take;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= LCFG_FRONT_RST;
        end else if (ce_i) begin
            q <= d;
        end
    end

    // upper lanes are unused: the register is 16 bits wide
    assign bus.req   = take;
    assign bus.we    = we_i;
    assign bus.idx   = adr_i[7:2];
    assign bus.wdata = dat_i[15:0];
    assign bus.wsel  = sel_i[1:0];
    assign ack_o     = q.ack;
endmodule // lcfg_wb_front
`default_nettype wire

/* verilog/lcfg_lane_d.sv */
// lane d configuration register with its effective-value logic
//
// Functional notes
// - bits 15:12 read zero, writes dropped
// - clock compensation enable or'ed with global
// - select bits route pin source
// - pin select bits or'ed with global
// - signal-loss enable and'ed; off hides loss
// - upper line bit locked while strap high
// - lower line bit locked while strap high
// - emphasis bits or'ed with global bits
// - loopback from lane bit or control
// - pattern test or'ed, locked by pin
// - alignment needs lane, pin and global
// - power down from lane bit or control
//
// Decided for this implementation: the address map and the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
module lcfg_lane_d (
    input  wire logic                           CLK_I,
    input  wire logic                           RST_I,
    input  wire logic                           CE_I,
    input  wire logic                           CYC_I,
    input  wire logic                           STB_I,
    input  wire logic                           WE_I,
    input  wire logic [lcfg_pkg::LCFG_ADR_W-1:0] ADR_I,
    input  wire logic [3:0]                     SEL_I,
    input  wire logic [lcfg_pkg::LCFG_DAT_W-1:0] DAT_I,
    output logic      [lcfg_pkg::LCFG_DAT_W-1:0] DAT_O,
    output logic                                ACK_O,
    input  wire logic [lcfg_pkg::LCFG_REG_W-1:0] GLOBAL_CFG_I,
    input  wire logic [lcfg_pkg::LCFG_REG_W-1:0] CONTROL0_I,
    input  wire logic [lcfg_pkg::LCFG_REG_W-1:0] STATUS22_I,
    input  wire logic                           LINE_CFG_STRAP_UPPER_PIN_I,
    input  wire logic                           LINE_CFG_STRAP_LOWER_PIN_I,
    input  wire logic                           PATTERN_TEST_PIN_I,
    input  wire logic                           ALIGNMENT_ENABLE_PIN_I,
    input  wire logic                           HSTL_SELECT_I,
    input  wire logic                           COMMA_DETECTED_I,
    input  wire logic                           SIGNAL_LOSS_RAW_I,
    output logic                                CLK_TOL_COMP_EN_O,
    output logic      [1:0]                     MF_SEL_O,
    output logic                                SIGNAL_LOSS_DET_EN_O,
    output logic                                SIGNAL_LOSS_CONDITION_O,
    output logic                                LINE_CFG_UPPER_BIT_O,
    output logic                                LINE_CFG_LOWER_BIT_O,
    output logic                                EMPHASIS_UPPER_BIT_O,
    output logic                                EMPHASIS_LOWER_BIT_O,
    output logic                                LOOPBACK_EN_O,
    output logic                                PRBS_EN_O,
    output logic                                ALIGN_EN_O,
    output logic                                POWER_DOWN_O,
    output logic                                LANE_D_MULTIFUNCTION_PIN_O
);
    import lcfg_pkg::*;

    lcfg_core_t  q;
    lcfg_core_t  d;
    logic [11:0] or_term;
    logic [15:0] eff_next;
    logic [15:0] lock;
    logic [15:0] wr_mask;
    logic [31:0] rd_value;
    lcfg_mf_t    mf_sel;

    lcfg_bus_if bus ();

    lcfg_wb_front u_front (
        .clk_i (CLK_I),
        .rst_i (RST_I),
        .ce_i  (CE_I),
        .cyc_i (CYC_I),
        .stb_i (STB_I),
        .we_i  (WE_I),
        .adr_i (ADR_I),
        .sel_i (SEL_I),
        .dat_i (DAT_I),
        .ack_o (ACK_O),
        .bus   (bus.front)
    );

    function automatic logic hit(
        input logic [5:0] idx,
        input logic [5:0] target
    );
        return idx == target;
    endfunction

    function automatic logic [15:0] lane_mask(input logic [1:0] sel);
        return {{8{sel[1]}}, {8{sel[0]}}};
    endfunction

    function automatic logic mf_route(
        input lcfg_mf_t s,
        input logic     hstl,
        input logic     comma,
        input logic     loss,
        input logic     pass
    );
        logic r;
        r = 1'b0;
        case (s)
            MF_SIGNALLING: r = hstl;
            MF_COMMA:      r = comma;
            MF_LOSS:       r = loss;
            MF_PRBS_PASS:  r = pass;
            default:       r = 1'b0;
        endcase
        return r;
    endfunction

    // fields that simply or with the global register
    for (genvar i = 0; i < LCFG_FLD_W; i++) begin : g_or
        assign or_term[i] = q.cfg[i] | (GLOBAL_CFG_I[i] & LCFG_OR_MASK[i]);
    end

    always_comb begin
        eff_next           = {4'h0, or_term};
        eff_next[B_CTC]    = or_term[B_CTC];
        eff_next[B_MF_HI]  = or_term[B_MF_HI];
        eff_next[B_MF_LO]  = or_term[B_MF_LO];
        eff_next[B_LOSS]   = q.cfg[B_LOSS] & GLOBAL_CFG_I[B_LOSS];
        eff_next[B_CFG_UP] = or_term[B_CFG_UP];
        eff_next[B_CFG_LO] = or_term[B_CFG_LO];
        eff_next[B_EMP_UP] = or_term[B_EMP_UP];
        eff_next[B_EMP_LO] = or_term[B_EMP_LO];
        eff_next[B_LPBK]   = q.cfg[B_LPBK] | CONTROL0_I[C0_LPBK];
        eff_next[B_PRBS]   = or_term[B_PRBS];
        eff_next[B_ALIGN]  = q.cfg[B_ALIGN] & ALIGNMENT_ENABLE_PIN_I
                           & GLOBAL_CFG_I[B_ALIGN];
        eff_next[B_PWDN]   = q.cfg[B_PWDN] | CONTROL0_I[C0_PWDN];
        // pin levels, for software to see why a write was refused
        eff_next[P_STRAP_UP] = LINE_CFG_STRAP_UPPER_PIN_I;
        eff_next[P_STRAP_LO] = LINE_CFG_STRAP_LOWER_PIN_I;
        eff_next[P_PATTERN]  = PATTERN_TEST_PIN_I;
        eff_next[P_ALIGN]    = ALIGNMENT_ENABLE_PIN_I;
    end

    assign mf_sel = lcfg_mf_t'(eff_next[B_MF_HI:B_MF_LO]);

    always_comb begin
        lock           = 16'h0000;
        lock[B_CFG_UP] = LINE_CFG_STRAP_UPPER_PIN_I;
        lock[B_CFG_LO] = LINE_CFG_STRAP_LOWER_PIN_I;
        lock[B_PRBS]   = PATTERN_TEST_PIN_I;
        // reserved nibble never reaches storage
        wr_mask = LCFG_WMASK & lane_mask(bus.wsel) & ~lock;
    end

    always_comb begin
        rd_value = 32'h00000000;
        if (hit(bus.idx, LCFG_IDX_CFG)) begin
            rd_value = {16'h0000, 4'h0, q.cfg};
        end else if (hit(bus.idx, LCFG_IDX_EFF)) begin
            rd_value = {16'h0000, q.eff};
        end else begin
            rd_value = 32'h00000000;
        end
    end

    always_comb begin
        d          = q;
        d.eff      = eff_next;
        // loss is hidden whenever detection is off
        d.sig_loss = eff_next[B_LOSS] & SIGNAL_LOSS_RAW_I;
        d.mf_pin   = mf_route(mf_sel,
                              HSTL_SELECT_I,
                              COMMA_DETECTED_I,
                              STATUS22_I[S22_LOSS],
                              STATUS22_I[S22_PRBS]);
        if (bus.req) begin
            if (bus.we) begin
                if (hit(bus.idx, LCFG_IDX_CFG)) begin
                    // locked bits keep their value, either way
                    d.cfg = (q.cfg & ~wr_mask[11:0])
                          | (bus.wdata[11:0] & wr_mask[11:0]);
                end
            end else begin
                d.rdata = rd_value;
            end
        end
    end

    // effective outputs lag the stored field by one clock
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            q <= LCFG_CORE_RST;
        end else if (CE_I) begin
            q <= d;
        end
    end

    assign DAT_O                      = q.rdata;
    assign CLK_TOL_COMP_EN_O          = q.eff[B_CTC];
    assign MF_SEL_O                   = q.eff[B_MF_HI:B_MF_LO];
    assign SIGNAL_LOSS_DET_EN_O       = q.eff[B_LOSS];
    assign SIGNAL_LOSS_CONDITION_O    = q.sig_loss;
    assign LINE_CFG_UPPER_BIT_O       = q.eff[B_CFG_UP];
    assign LINE_CFG_LOWER_BIT_O       = q.eff[B_CFG_LO];
    assign EMPHASIS_UPPER_BIT_O       = q.eff[B_EMP_UP];
    assign EMPHASIS_LOWER_BIT_O       = q.eff[B_EMP_LO];
    assign LOOPBACK_EN_O              = q.eff[B_LPBK];
    assign PRBS_EN_O                  = q.eff[B_PRBS];
    assign ALIGN_EN_O                 = q.eff[B_ALIGN];
    assign POWER_DOWN_O               = q.eff[B_PWDN];
    assign LANE_D_MULTIFUNCTION_PIN_O = q.mf_pin;
endmodule // lcfg_lane_d
`default_nettype wire

/* dv/lcfg_lane_d_props.sv */
// assertion checker for the lane d configuration block
`timescale 1ns/1ns
`default_nettype none
module lcfg_lane_d_props (
    input wire logic                            CLK_I,
    input wire logic                            RST_I,
    input wire logic                            CE_I,
    input wire logic                            CYC_I,
    input wire logic                            STB_I,
    input wire logic                            WE_I,
    input wire logic [lcfg_pkg::LCFG_ADR_W-1:0] ADR_I,
    input wire logic [lcfg_pkg::LCFG_DAT_W-1:0] DAT_O,
    input wire logic                            ACK_O,
    input wire logic [lcfg_pkg::LCFG_REG_W-1:0] GLOBAL_CFG_I,
    input wire logic [lcfg_pkg::LCFG_REG_W-1:0] CONTROL0_I,
    input wire logic [lcfg_pkg::LCFG_REG_W-1:0] STATUS22_I,
    input wire logic                            ALIGNMENT_ENABLE_PIN_I,
    input wire logic                            HSTL_SELECT_I,
    input wire logic                            COMMA_DETECTED_I,
    input wire logic                            SIGNAL_LOSS_RAW_I,
    input wire logic                            CLK_TOL_COMP_EN_O,
    input wire logic [1:0]                      MF_SEL_O,
    input wire logic                            SIGNAL_LOSS_DET_EN_O,
    input wire logic                            SIGNAL_LOSS_CONDITION_O,
    input wire logic                            LINE_CFG_UPPER_BIT_O,
    input wire logic                            LINE_CFG_LOWER_BIT_O,
    input wire logic                            EMPHASIS_UPPER_BIT_O,
    input wire logic                            EMPHASIS_LOWER_BIT_O,
    input wire logic                            LOOPBACK_EN_O,
    input wire logic                            PRBS_EN_O,
    input wire logic                            ALIGN_EN_O,
    input wire logic                            POWER_DOWN_O,
    input wire logic                            LANE_D_MULTIFUNCTION_PIN_O
);
    import lcfg_pkg::*;
    // run_q: previous edge was a live one, so outputs follow inputs
    logic       run_q;
    logic [7:0] g_or;
    logic [7:0] o_or;
    always_ff @(posedge CLK_I) run_q <= CE_I && !RST_I;
    assign g_or = {GLOBAL_CFG_I[11:9], GLOBAL_CFG_I[7:4], GLOBAL_CFG_I[2]};
    assign o_or = {CLK_TOL_COMP_EN_O, MF_SEL_O, LINE_CFG_UPPER_BIT_O,
                   LINE_CFG_LOWER_BIT_O, EMPHASIS_UPPER_BIT_O,
                   EMPHASIS_LOWER_BIT_O, PRBS_EN_O};
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    sequence s_take; CE_I && CYC_I && STB_I && !ACK_O; endsequence
    sequence s_rd_cfg; s_take ##0 (!WE_I && ADR_I[7:2] == LCFG_IDX_CFG);
    endsequence
    property p_rsv; s_rd_cfg |=> ACK_O && DAT_O[31:12] == 20'h00000;
    endproperty
    property p_or; run_q |-> (o_or & $past(g_or)) == $past(g_or); endproperty
    property p_mfpin; run_q |-> LANE_D_MULTIFUNCTION_PIN_O ==
        (MF_SEL_O == 2'h0 ? $past(HSTL_SELECT_I) :
         MF_SEL_O == 2'h1 ? $past(COMMA_DETECTED_I) :
         MF_SEL_O == 2'h2 ? $past(STATUS22_I[3]) : $past(STATUS22_I[7]));
    endproperty
    property p_loss_off; run_q && !$past(GLOBAL_CFG_I[8]) |->
        !SIGNAL_LOSS_DET_EN_O; endproperty
    property p_loss_cond; run_q |-> SIGNAL_LOSS_CONDITION_O ==
        (SIGNAL_LOSS_DET_EN_O && $past(SIGNAL_LOSS_RAW_I)); endproperty
    property p_lpbk; run_q && $past(CONTROL0_I[14]) |-> LOOPBACK_EN_O;
    endproperty
    property p_align; run_q && !$past(ALIGNMENT_ENABLE_PIN_I) |-> !ALIGN_EN_O;
    endproperty
    property p_pwdn; run_q && $past(CONTROL0_I[11]) |-> POWER_DOWN_O;
    endproperty
    // ack, alignment enable and multifunction select stay cleared on the first edge out of reset
    property p_rst; $past(RST_I) |-> !ACK_O && !ALIGN_EN_O && !MF_SEL_O;
    endproperty
    a_rsv: assert property (p_rsv)
        else $error("reserved bits read nonzero");
    a_or: assert property (p_or)
        else $error("global bit not or-ed into output");
    a_mfpin: assert property (p_mfpin)
        else $error("multifunction pin wrong source");
    a_loss_off: assert property (p_loss_off)
        else $error("loss detect enabled against global");
    a_loss_cond: assert property (p_loss_cond)
        else $error("loss condition not gated");
    a_lpbk: assert property (p_lpbk)
        else $error("loopback missing");
    a_align: assert property (p_align)
        else $error("alignment active with pin low");
    a_pwdn: assert property (p_pwdn)
        else $error("power down missing");
    a_rst: assert property (p_rst)
        else $error("outputs not cleared by reset");
endmodule // lcfg_lane_d_props
bind lcfg_lane_d lcfg_lane_d_props u_props (.CLK_I(CLK_I), .RST_I(RST_I),
    .CE_I(CE_I), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I),
    .DAT_O(DAT_O), .ACK_O(ACK_O), .GLOBAL_CFG_I(GLOBAL_CFG_I),
    .CONTROL0_I(CONTROL0_I), .STATUS22_I(STATUS22_I),
    .ALIGNMENT_ENABLE_PIN_I(ALIGNMENT_ENABLE_PIN_I),
    .HSTL_SELECT_I(HSTL_SELECT_I), .COMMA_DETECTED_I(COMMA_DETECTED_I),
    .SIGNAL_LOSS_RAW_I(SIGNAL_LOSS_RAW_I),
    .CLK_TOL_COMP_EN_O(CLK_TOL_COMP_EN_O), .MF_SEL_O(MF_SEL_O),
    .SIGNAL_LOSS_DET_EN_O(SIGNAL_LOSS_DET_EN_O),
    .SIGNAL_LOSS_CONDITION_O(SIGNAL_LOSS_CONDITION_O),
    .LINE_CFG_UPPER_BIT_O(LINE_CFG_UPPER_BIT_O),
    .LINE_CFG_LOWER_BIT_O(LINE_CFG_LOWER_BIT_O),
    .EMPHASIS_UPPER_BIT_O(EMPHASIS_UPPER_BIT_O),
    .EMPHASIS_LOWER_BIT_O(EMPHASIS_LOWER_BIT_O),
    .LOOPBACK_EN_O(LOOPBACK_EN_O), .PRBS_EN_O(PRBS_EN_O),
    .ALIGN_EN_O(ALIGN_EN_O), .POWER_DOWN_O(POWER_DOWN_O),
    .LANE_D_MULTIFUNCTION_PIN_O(LANE_D_MULTIFUNCTION_PIN_O));
`default_nettype wire

/* dv/test_lane_d_config_register.sv */
// self-checking bench for the lane d configuration block
`timescale 1ns/1ns
`default_nettype none
module test_lane_d_config_register;
    import lcfg_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0, rd;
    logic [15:0] g = 16'h0102, c0 = 16'h0000, s22 = 16'h0000;
    logic [3:0]  pin = 4'h1; // upper strap, lower strap, pattern, align
    logic        hstl = 1'b0, comma = 1'b0, lraw = 1'b0, ce = 1'b1;
    logic [15:0] fz;
    wire logic [31:0] dat_o;
    wire logic [11:0] o;
    wire logic        ack, mfp, lcond;
    int          n_mismatch = 0, n_tests = 0;
    logic [11:0] tc [4] = '{12'h000, 12'h102, 12'ha5a, 12'h5a5};
    logic [15:0] tg [4] = '{16'hffff, 16'h0000, 16'h0102, 16'h0a50};
    logic [15:0] tk [4] = '{16'h4800, 16'h0000, 16'h0800, 16'h4000};
    logic [3:0]  lp [3] = '{4'he, 4'h1, 4'he};
    logic [11:0] lw [3] = '{12'hfff, 12'h0c4, 12'h000};
    logic [11:0] le [3] = '{12'hf3b, 12'h0c4, 12'h0c4};
    always #25 clk = ~clk;
    lcfg_lane_d dut_u (.CLK_I(clk), .RST_I(rst), .CE_I(ce), .CYC_I(cyc),
        .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat),
        .DAT_O(dat_o), .ACK_O(ack), .GLOBAL_CFG_I(g), .CONTROL0_I(c0),
        .STATUS22_I(s22), .LINE_CFG_STRAP_UPPER_PIN_I(pin[3]),
        .LINE_CFG_STRAP_LOWER_PIN_I(pin[2]), .PATTERN_TEST_PIN_I(pin[1]),
        .ALIGNMENT_ENABLE_PIN_I(pin[0]), .HSTL_SELECT_I(hstl),
        .COMMA_DETECTED_I(comma), .SIGNAL_LOSS_RAW_I(lraw),
        .CLK_TOL_COMP_EN_O(o[11]), .MF_SEL_O(o[10:9]),
        .SIGNAL_LOSS_DET_EN_O(o[8]), .SIGNAL_LOSS_CONDITION_O(lcond),
        .LINE_CFG_UPPER_BIT_O(o[7]), .LINE_CFG_LOWER_BIT_O(o[6]),
        .EMPHASIS_UPPER_BIT_O(o[5]), .EMPHASIS_LOWER_BIT_O(o[4]),
        .LOOPBACK_EN_O(o[3]), .PRBS_EN_O(o[2]), .ALIGN_EN_O(o[1]),
        .POWER_DOWN_O(o[0]), .LANE_D_MULTIFUNCTION_PIN_O(mfp));
    task automatic test_done;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one classic cycle; waits for ack, bounded
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [11:0] d, input logic [1:0] s);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        sel <= {2'b00, s};
        dat <= {20'hfffff, d}; // upper junk must be dropped
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 16);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            n_mismatch++;
            test_done();
        end
    endtask
    function automatic logic [15:0] eff(input logic [11:0] c);
        logic [11:0] e;
        e = c | g[11:0];
        e[8] = c[8] & g[8];
        e[1] = c[1] & g[1] & pin[0];
        e[3] = c[3] | c0[14];
        e[0] = c[0] | c0[11];
        return {pin, e};
    endfunction
    task automatic drive(input logic [15:0] gv, cv, input logic [3:0] pv);
        @(posedge clk);
        g   <= gv;
        c0  <= cv;
        pin <= pv;
        repeat (2) @(posedge clk);
    endtask
    // register, effective view and every output against the rules
    task automatic state(input logic [11:0] c);
        logic [15:0] e;
        logic        m;
        e = eff(c);
        m = e[10] ? (e[9] ? s22[7] : s22[3]) : (e[9] ? comma : hstl);
        wb(1'b0, 8'h50, 12'h000, 2'h0);
        chk(rd, {20'h0, c});
        wb(1'b0, 8'h54, 12'h000, 2'h0);
        chk(rd, {16'h0, e});
        chk({20'h0, o}, {20'h0, e[11:0]});
        chk({31'h0, mfp}, {31'h0, m});
        chk({31'h0, lcond}, {31'h0, e[8] & lraw});
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        state(12'h102);
        wb(1'b1, 8'h50, 12'hfff, 2'h3);
        state(12'hfff);
        wb(1'b1, 8'h50, 12'h000, 2'h1); // low byte only
        state(12'hf00);
        wb(1'b1, 8'h50, 12'h5aa, 2'h2); // high byte only
        wb(1'b1, 8'h40, 12'hfff, 2'h3); // unmapped, dropped
        wb(1'b1, 8'h54, 12'h000, 2'h3); // read-only view
        wb(1'b0, 8'h40, 12'h000, 2'h0);
        chk(rd, 32'h0);
        state(12'h500);
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, 8'h50, tc[i], 2'h3);
            lraw <= i[0];
            drive(tg[i], tk[i], 4'h1);
            state(tc[i]);
        end
        drive(16'h0000, 16'h0000, 4'h1);
        for (int i = 0; i < 8; i++) begin
            hstl  <= ~i[2];
            comma <= i[2];
            s22   <= i[2] ? 16'h0080 : 16'h0008;
            wb(1'b1, 8'h50, {1'b0, i[1:0], 9'h000}, 2'h3);
            state({1'b0, i[1:0], 9'h000});
        end
        // straps and pattern pin high lock bits 7, 6 and 2 in either direction
        for (int i = 0; i < 3; i++) begin
            drive(16'h0102, 16'h0000, lp[i]);
            wb(1'b1, 8'h50, lw[i], 2'h3);
            state(le[i]);
        end
        // enable low: inputs move, outputs must not follow them
        fz = eff(le[2]);
        ce <= 1'b0;
        drive(16'hffff, 16'h4800, 4'h1);
        chk({20'h0, o}, {20'h0, fz[11:0]});
        ce <= 1'b1;
        drive(16'h0102, 16'h0000, 4'h1);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        state(12'h102);
        test_done();
    end
endmodule // test_lane_d_config_register
`default_nettype wire
